// [rtl/fawc_flash_ctrl.sv]
/*
 * Flash read wait-state, prefetch, cache and program/erase gate.
 * Assumes the array returns data for arr_addr_o once the wait count
 * has elapsed, and all config inputs come from logic on clk_i.
 */
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Extension is zero to 80 MHz, one above; far access forces it.
// - Wait states apply only to non-sequential reads; sequential use prefetch.
// - After each read except a cache hit, the next sequential word is fetched ahead unless its module is busy.
// - Cacheable reads: hit costs no wait, miss one extra wait.
// - Module supplying reads cannot be erased or programmed; command refused.
// - Any module may be erased while reads come from one other.
// - Data module four accepts erase/program while others are read.
// - Page program completes within 3.5 ms, typically 3 ms.
// - Control sequencing adds a few system cycles to each operation.
// - Out of reset no module protection is installed.
module fawc_flash_ctrl #(
    parameter int PROG_CYC_P = fawc_pkg::PROG_CYC,
    parameter int PROG_MAX_CYC_P = fawc_pkg::PROG_MAX_CYC,
    parameter int ERASE_CYC_P = fawc_pkg::ERASE_CYC,
    parameter int ERASE_MAX_CYC_P = fawc_pkg::ERASE_MAX_CYC,
    parameter int CACHE_LINES = 2**fawc_pkg::IDX_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Configuration
    input wire logic [fawc_pkg::WS_W-1:0] read_wait_count_i,
    input wire logic wait_extension_i,
    input wire logic far_access_select_i,
    input wire logic sram_exec_i,
    // Internal memory bus read port
    input wire logic req_valid_i,
    input wire fawc_pkg::fawc_req_t req_i,
    output logic req_ready_o,
    output logic rvalid_o,
    output logic [fawc_pkg::DATA_W-1:0] rdata_o,
    // Flash array read port
    output logic [fawc_pkg::ADDR_W-1:0] arr_addr_o,
    input wire logic [fawc_pkg::DATA_W-1:0] arr_rdata_i,
    // Program and erase commands
    input wire logic cmd_valid_i,
    input wire fawc_pkg::fawc_cmd_t cmd_i,
    output logic cmd_ready_o,
    output logic cmd_refused_o,
    output logic pe_start_o,
    output fawc_pkg::fawc_cmd_t pe_cmd_o,
    output logic pe_busy_o,
    output logic pe_done_o,
    // Protection
    input wire logic lock_valid_i,
    input wire logic [fawc_pkg::MOD_W-1:0] lock_mod_i,
    output logic [2**fawc_pkg::MOD_W-1:0] prot_mask_o
);
    localparam int AW = fawc_pkg::ADDR_W;
    localparam int MW = fawc_pkg::MOD_W;
    localparam int WW = fawc_pkg::WS_W;
    localparam int IW = fawc_pkg::IDX_W;
    localparam int LW = fawc_pkg::LAT_W;
    localparam int TW = fawc_pkg::TMR_W;

    function automatic logic [WW:0] wait_total(
        input logic [WW-1:0] ws,
        input logic ext,
        input logic miss
    );
        wait_total = {1'b0, ws} + {{WW{1'b0}}, ext} + {{WW{1'b0}}, miss};
    endfunction

    function automatic logic [MW-1:0] mod_of(input logic [AW-1:0] addr);
        mod_of = addr[fawc_pkg::MOD_LSB +: MW];
    endfunction

    // Reset synchroniser
    logic rst_meta_reg;
    logic rst_n;
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    fawc_pkg::fawc_rd_state_t st_reg;
    logic [WW:0] cnt_reg;
    logic [AW-1:0] acc_addr_reg;
    logic acc_cached_reg;
    logic [AW-1:0] arr_addr_reg;
    logic [fawc_pkg::DATA_W-1:0] rdata_reg;
    logic rvalid_reg;
    logic pf_vld_reg;
    logic [AW-1:0] pf_addr_reg;
    logic [fawc_pkg::DATA_W-1:0] pf_data_reg;
    logic [MW-1:0] src_mod_reg;
    logic src_vld_reg;
    logic [CACHE_LINES-1:0] c_vld_reg;
    logic [fawc_pkg::DATA_W-1:0] c_data [CACHE_LINES];
    logic [AW-IW-1:0] c_tag [CACHE_LINES];
    fawc_pkg::fawc_cmd_t pe_cmd_reg;
    logic pe_start_reg;
    logic refused_reg;
    logic [2**MW-1:0] prot_reg;
    logic pe_busy;

    // Read side decode
    wire logic [MW-1:0] req_mod = mod_of(req_i.addr);
    wire logic [IW-1:0] req_idx = req_i.addr[IW-1:0];
    wire logic [IW-1:0] acc_idx = acc_addr_reg[IW-1:0];
    wire logic req_blocked = pe_busy && (req_mod == pe_cmd_reg.mod_sel);
    wire logic take = req_valid_i && req_ready_o;
    wire logic c_hit = req_i.cached && c_vld_reg[req_idx]
        && (c_tag[req_idx] == req_i.addr[AW-1:IW]);
    wire logic pf_hit = pf_vld_reg && (pf_addr_reg == req_i.addr);
    wire logic ext_eff = wait_extension_i | far_access_select_i;
    wire logic [AW-1:0] req_next = req_i.addr + AW'(1);
    wire logic [AW-1:0] acc_next = acc_addr_reg + AW'(1);
    wire logic req_pf_ok = !(pe_busy && mod_of(req_next) == pe_cmd_reg.mod_sel);
    wire logic acc_pf_ok = !(pe_busy && mod_of(acc_next) == pe_cmd_reg.mod_sel);
    wire logic rd_end = (st_reg == fawc_pkg::RD_WAIT) && (cnt_reg == '0);
    wire logic fill = rd_end && acc_cached_reg;
    wire logic [WW:0] seq_wait = wait_total(read_wait_count_i, ext_eff, 1'b0);

    assign req_ready_o = (st_reg == fawc_pkg::RD_IDLE) && !req_blocked;

    // Program/erase decode
    wire logic [MW-1:0] cmd_mod = cmd_i.mod_sel;
    wire logic cmd_take = cmd_valid_i && cmd_ready_o;
    wire logic src_clash = (src_vld_reg && cmd_mod == src_mod_reg)
        || (st_reg != fawc_pkg::RD_IDLE && cmd_mod == mod_of(arr_addr_reg))
        || (take && cmd_mod == req_mod);
    wire logic refuse = src_clash || prot_reg[cmd_mod]
        || (32'(cmd_mod) >= fawc_pkg::NUM_MOD);
    wire logic pe_go = cmd_take && !refuse;
    wire logic [TW-1:0] pe_len = (cmd_i.op == fawc_pkg::PE_PROG)
        ? TW'(PROG_CYC_P + fawc_pkg::PE_OVH_CYC)
        : TW'(ERASE_CYC_P + fawc_pkg::PE_OVH_CYC);

    assign cmd_ready_o = !pe_busy;

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= fawc_pkg::RD_IDLE;
            cnt_reg <= '0;
            acc_addr_reg <= '0;
            acc_cached_reg <= 1'b0;
            arr_addr_reg <= '0;
            rdata_reg <= '0;
            rvalid_reg <= 1'b0;
            pf_vld_reg <= 1'b0;
            pf_addr_reg <= '0;
            pf_data_reg <= '0;
        end
        else
        begin
            rvalid_reg <= 1'b0;
            case (st_reg)
                fawc_pkg::RD_IDLE:
                begin
                    if (take)
                    begin
                        acc_addr_reg <= req_i.addr;
                        acc_cached_reg <= req_i.cached;
                        if (c_hit)
                        begin
                            rdata_reg <= c_data[req_idx];
                            rvalid_reg <= 1'b1;
                        end
                        else if (pf_hit)
                        begin
                            rdata_reg <= pf_data_reg;
                            rvalid_reg <= 1'b1;
                            pf_vld_reg <= 1'b0;
                            if (req_pf_ok)
                            begin
                                st_reg <= fawc_pkg::RD_PREF;
                                cnt_reg <= seq_wait;
                                arr_addr_reg <= req_next;
                            end
                        end
                        else
                        begin
                            st_reg <= fawc_pkg::RD_WAIT;
                            cnt_reg <= wait_total(read_wait_count_i, ext_eff,
                                req_i.cached);
                            arr_addr_reg <= req_i.addr;
                            pf_vld_reg <= 1'b0;
                        end
                    end
                end
                fawc_pkg::RD_WAIT:
                begin
                    if (cnt_reg == '0)
                    begin
                        rdata_reg <= arr_rdata_i;
                        rvalid_reg <= 1'b1;
                        if (acc_pf_ok)
                        begin
                            st_reg <= fawc_pkg::RD_PREF;
                            cnt_reg <= seq_wait;
                            arr_addr_reg <= acc_next;
                        end
                        else
                        begin
                            st_reg <= fawc_pkg::RD_IDLE;
                        end
                    end
                    else
                    begin
                        cnt_reg <= cnt_reg - (WW+1)'(1);
                    end
                end
                fawc_pkg::RD_PREF:
                begin
                    if (cnt_reg == '0)
                    begin
                        pf_data_reg <= arr_rdata_i;
                        pf_addr_reg <= arr_addr_reg;
                        pf_vld_reg <= !pe_go;
                        st_reg <= fawc_pkg::RD_IDLE;
                    end
                    else
                    begin
                        cnt_reg <= cnt_reg - (WW+1)'(1);
                    end
                end
                default:
                begin
                    st_reg <= fawc_pkg::RD_IDLE;
                end
            endcase
            // Stale after a program or erase begins
            if (pe_go && st_reg != fawc_pkg::RD_PREF)
            begin
                pf_vld_reg <= 1'b0;
            end
        end
    end

    // Cache storage needs no reset; valid bits guard it
    always_ff @(posedge clk_i)
    begin
        if (fill)
        begin
            c_data[acc_idx] <= arr_rdata_i;
            c_tag[acc_idx] <= acc_addr_reg[AW-1:IW];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            c_vld_reg <= '0;
            src_mod_reg <= '0;
            src_vld_reg <= 1'b0;
            pe_cmd_reg <= '0;
            pe_start_reg <= 1'b0;
            refused_reg <= 1'b0;
            prot_reg <= fawc_pkg::PROT_RST;
        end
        else
        begin
            pe_start_reg <= pe_go;
            refused_reg <= cmd_take && refuse;
            if (pe_go)
            begin
                pe_cmd_reg <= cmd_i;
                c_vld_reg <= '0;
            end
            // Fill wins; its module is shielded from the operation
            if (fill)
            begin
                c_vld_reg[acc_idx] <= 1'b1;
            end
            // Take wins over the switch to SRAM
            if (take)
            begin
                src_mod_reg <= req_mod;
                src_vld_reg <= 1'b1;
            end
            else if (sram_exec_i)
            begin
                src_vld_reg <= 1'b0;
            end
            if (lock_valid_i)
            begin
                prot_reg[lock_mod_i] <= 1'b1;
            end
        end
    end

    fawc_pe_timer #(
        .CNT_W(TW)
    ) u_timer (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .start_i(pe_go),
        .len_i(pe_len),
        .busy_o(pe_busy),
        .done_o(pe_done_o)
    );

    assign rvalid_o = rvalid_reg;
    assign rdata_o = rdata_reg;
    assign arr_addr_o = arr_addr_reg;
    assign cmd_refused_o = refused_reg;
    assign pe_start_o = pe_start_reg;
    assign pe_cmd_o = pe_cmd_reg;
    assign pe_busy_o = pe_busy;
    assign prot_mask_o = prot_reg;

    // Helper counters for the checks below
    logic [LW-1:0] lat_reg;
    logic [LW-1:0] exp_reg;
    logic dem_reg;
    logic [TW-1:0] busy_cnt_reg;
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lat_reg <= '0;
            exp_reg <= '0;
            dem_reg <= 1'b0;
            busy_cnt_reg <= '0;
        end
        else
        begin
            // Counts edges after the take edge
            lat_reg <= take ? '0 : lat_reg + LW'(1);
            if (take)
            begin
                dem_reg <= !c_hit && !pf_hit;
                exp_reg <= LW'(wait_total(read_wait_count_i, ext_eff,
                    req_i.cached)) + LW'(1);
            end
            busy_cnt_reg <= pe_go ? '0
                : (pe_busy ? busy_cnt_reg + TW'(1) : busy_cnt_reg);
        end
    end

    rd_latency_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        rvalid_o && dem_reg |-> lat_reg == exp_reg)
        else $error("read answer latency differs from wait count");
    cache_hit_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        take && c_hit |=> rvalid_o && rdata_o == $past(c_data[req_idx]))
        else $error("cache hit not answered next cycle");
    seq_fast_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        take && !c_hit && pf_hit |=> rvalid_o
            && rdata_o == $past(pf_data_reg))
        else $error("prefetched word not answered next cycle");
    pref_next_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        rd_end && acc_pf_ok |=> st_reg == fawc_pkg::RD_PREF
            && arr_addr_o == $past(acc_addr_reg) + AW'(1))
        else $error("prefetch of next word not started");
    far_ext_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        take && !c_hit && !pf_hit && far_access_select_i
            |=> cnt_reg > {1'b0, $past(read_wait_count_i)})
        else $error("far access did not extend wait");
    src_block_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        cmd_take && src_vld_reg && cmd_mod == src_mod_reg
            |=> cmd_refused_o && !pe_start_o ##1 !pe_busy_o)
        else $error("command accepted on reading module");
    other_ok_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        cmd_take && src_vld_reg && cmd_mod != src_mod_reg && !take
            && st_reg == fawc_pkg::RD_IDLE && !prot_reg[cmd_mod]
            && 32'(cmd_mod) < fawc_pkg::NUM_MOD |=> pe_start_o && pe_busy_o)
        else $error("command on idle module refused");
    data_mod_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        cmd_take && cmd_mod == fawc_pkg::DATA_MOD && !prot_reg[cmd_mod]
            && !src_clash |=> pe_start_o)
        else $error("data module command refused");
    prog_time_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        pe_busy_o && pe_cmd_o.op == fawc_pkg::PE_PROG
            |-> 32'(busy_cnt_reg) < PROG_MAX_CYC_P)
        else $error("page program exceeds its longest time");
    erase_time_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        pe_busy_o && pe_cmd_o.op == fawc_pkg::PE_ERASE
            |-> 32'(busy_cnt_reg) < ERASE_MAX_CYC_P)
        else $error("erase exceeds its longest time");
    pe_len_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        $fell(pe_busy_o) && pe_cmd_o.op == fawc_pkg::PE_PROG
            |-> 32'(busy_cnt_reg) == PROG_CYC_P + fawc_pkg::PE_OVH_CYC
            && pe_done_o)
        else $error("program length lacks sequencing overhead");
endmodule // fawc_flash_ctrl
`default_nettype wire

// [rtl/fawc_pe_timer.sv]
/*
 * Down counter that times one program or erase operation.
 * Assumes start is a one-cycle pulse and len is at least one.
 */
`timescale 1ns/10ps
`default_nettype none
module fawc_pe_timer #(
    parameter int CNT_W = 18
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Control
    input wire logic start_i,
    input wire logic [CNT_W-1:0] len_i,
    // Status
    output logic busy_o,
    output logic done_o
);
    logic [CNT_W-1:0] cnt_reg;
    logic busy_reg;
    logic done_reg;

    wire logic last = busy_reg && (cnt_reg == CNT_W'(1));

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_reg <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else
        begin
            done_reg <= last;
            if (start_i && !busy_reg)
            begin
                cnt_reg <= len_i;
                busy_reg <= 1'b1;
            end
            else if (busy_reg)
            begin
                cnt_reg <= cnt_reg - CNT_W'(1);
                busy_reg <= !last;
            end
        end
    end

    assign busy_o = busy_reg;
    assign done_o = done_reg;
endmodule // fawc_pe_timer
`default_nettype wire

// [rtl/fawc_pkg.sv]
/*
 * Shared constants and types for the flash access wait control block.
 * Assumes one 20 MHz system clock and a word-addressed flash array.
 */
package fawc_pkg;
    // Addressing and data
    localparam int ADDR_W = 20;
    localparam int DATA_W = 32;
    localparam int MOD_W = 3;
    localparam int MOD_LSB = 17;
    localparam int NUM_MOD = 5;
    localparam int PAGE_W = 8;
    localparam int WS_W = 3;
    localparam int IDX_W = 3;
    localparam logic [MOD_W-1:0] DATA_MOD = 3'h4;

    // Timing
    localparam int CLK_MHZ = 20;
    localparam int PROG_TYP_US = 3000;
    localparam int PROG_MAX_US = 3500;
    localparam int ERASE_TYP_US = 7000;
    localparam int ERASE_MAX_US = 8000;
    localparam int PROG_CYC = PROG_TYP_US * CLK_MHZ;
    localparam int PROG_MAX_CYC = PROG_MAX_US * CLK_MHZ;
    localparam int ERASE_CYC = ERASE_TYP_US * CLK_MHZ;
    localparam int ERASE_MAX_CYC = ERASE_MAX_US * CLK_MHZ;
    localparam int PE_OVH_CYC = 4;
    localparam int TMR_W = 18;
    localparam int LAT_W = 5;

    // Reset values
    localparam logic [2**MOD_W-1:0] PROT_RST = 8'h00;

    typedef enum logic [1:0] {
        RD_IDLE = 2'h0,
        RD_WAIT = 2'h1,
        RD_PREF = 2'h3
    } fawc_rd_state_t;

    typedef enum logic {
        PE_ERASE = 1'h0,
        PE_PROG = 1'h1
    } fawc_pe_op_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic cached;
    } fawc_req_t;

    typedef struct packed {
        fawc_pe_op_t op;
        logic [MOD_W-1:0] mod_sel;
        logic [PAGE_W-1:0] page;
    } fawc_cmd_t;
endpackage

// [tb/fawc_array_model.sv]
/*
 * Behavioural model of the flash array behind the read port.
 * Assumes the controller holds arr_addr_o steady for its wait count.
 */
`timescale 1ns/10ps
`default_nettype none
module fawc_array_model (
    // Clock
    input wire logic clk_i,
    // Array read port
    input wire logic [fawc_pkg::ADDR_W-1:0] addr_i,
    output logic [fawc_pkg::DATA_W-1:0] rdata_o
);
    logic [fawc_pkg::ADDR_W-1:0] addr_reg;
    logic [fawc_pkg::DATA_W-1:0] word;

    assign word = {12'hC3C, addr_i};

    always_ff @(posedge clk_i)
    begin
        addr_reg <= addr_i;
    end

    // array needs wait states
    // Fresh address gives inverted data, so a sample with no wait state never matches
    assign rdata_o = (addr_i == addr_reg) ? word : ~word;
endmodule // fawc_array_model
`default_nettype wire

// [tb/flash_access_wait_control_tb.sv]
/*
 * Self-checking bench for the flash access wait control block.
 * Assumes fawc_array_model on the array port and short PE counts.
 */
`timescale 1ns/10ps
`default_nettype none
module flash_access_wait_control_tb;
    localparam int PROG_L = 20;
    localparam int ERASE_L = 30;
    localparam int OVH = 4;
    logic clk_i;
    logic rstn_i;
    logic [fawc_pkg::WS_W-1:0] ws;
    logic ext;
    logic far;
    logic sram;
    logic req_valid;
    logic req_ready;
    logic rvalid;
    logic cmd_valid;
    logic cmd_ready;
    logic refused;
    logic pe_start;
    logic pe_busy;
    logic pe_done;
    logic lock_valid;
    logic [fawc_pkg::MOD_W-1:0] lock_mod;
    logic [7:0] prot;
    logic [fawc_pkg::DATA_W-1:0] rdata;
    logic [fawc_pkg::DATA_W-1:0] arr_rdata;
    logic [fawc_pkg::ADDR_W-1:0] arr_addr;
    fawc_pkg::fawc_req_t req;
    fawc_pkg::fawc_cmd_t cmd;
    fawc_pkg::fawc_cmd_t pe_cmd;
    int n_errors;
    int checks;
    int cycles;

    fawc_flash_ctrl #(
        .PROG_CYC_P(PROG_L),
        .PROG_MAX_CYC_P(40),
        .ERASE_CYC_P(ERASE_L),
        .ERASE_MAX_CYC_P(40),
        .CACHE_LINES(8)
    ) dut (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .read_wait_count_i(ws),
        .wait_extension_i(ext),
        .far_access_select_i(far),
        .sram_exec_i(sram),
        .req_valid_i(req_valid),
        .req_i(req),
        .req_ready_o(req_ready),
        .rvalid_o(rvalid),
        .rdata_o(rdata),
        .arr_addr_o(arr_addr),
        .arr_rdata_i(arr_rdata),
        .cmd_valid_i(cmd_valid),
        .cmd_i(cmd),
        .cmd_ready_o(cmd_ready),
        .cmd_refused_o(refused),
        .pe_start_o(pe_start),
        .pe_cmd_o(pe_cmd),
        .pe_busy_o(pe_busy),
        .pe_done_o(pe_done),
        .lock_valid_i(lock_valid),
        .lock_mod_i(lock_mod),
        .prot_mask_o(prot)
    );

    fawc_array_model array (
        .clk_i(clk_i),
        .addr_i(arr_addr),
        .rdata_o(arr_rdata)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic print_verdict;
        if (n_errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // Latency counts rising edges from the take edge to rvalid_o
    task automatic read(input logic [19:0] a, input logic c, input int exp);
        int lat;
        int t;
        @(negedge clk_i);
        req.addr = a;
        req.cached = c;
        req_valid = 1'b1;
        t = 0;
        while (req_ready !== 1'b1 && t < 200)
        begin
            @(negedge clk_i);
            t++;
        end
        @(posedge clk_i);
        @(negedge clk_i);
        req_valid = 1'b0;
        lat = 0;
        while (rvalid !== 1'b1 && lat < 40)
        begin
            @(negedge clk_i);
            lat++;
        end
        check("read latency", lat, exp);
        check("read data", rdata, {12'hC3C, a});
        @(negedge clk_i);
        check("rvalid pulse", rvalid, 1'b0);
    endtask

    task automatic pe_run(input logic op, input logic [2:0] m,
                          input logic ok);
        int len;
        int t;
        @(negedge clk_i);
        cmd.op = fawc_pkg::fawc_pe_op_t'(op);
        cmd.mod_sel = m;
        cmd.page = 8'h5A;
        cmd_valid = 1'b1;
        t = 0;
        while (cmd_ready !== 1'b1 && t < 200)
        begin
            @(negedge clk_i);
            t++;
        end
        @(posedge clk_i);
        @(negedge clk_i);
        cmd_valid = 1'b0;
        check("cmd refused", refused, !ok);
        check("pe start", pe_start, ok);
        if (ok)
        begin
            check("pe cmd", pe_cmd, cmd);
            len = 0;
            while (pe_busy === 1'b1 && len < 200)
            begin
                @(negedge clk_i);
                len++;
            end
            check("pe busy cycles", len, (op ? PROG_L : ERASE_L) + OVH);
            check("pe within max", len <= 40, 1'b1);
            check("pe done", pe_done, 1'b1);
        end
    endtask

    task automatic t_reset;
        check("prot after reset", prot, 8'h00);
        check("busy after reset", pe_busy, 1'b0);
    endtask

    // Wait counts one to four, with extension and with far access
    task automatic t_waits;
        int k;
        k = 0;
        for (int w = 1; w <= 4; w++)
            for (int e = 0; e < 3; e++)
            begin
                @(negedge clk_i);
                ws = w[2:0];
                ext = (e == 1);
                far = (e == 2);
                read(20'h00400 + 20'(k * 16), 1'b0, w + (e != 0) + 1);
                k++;
            end
    endtask

    task automatic t_prefetch;
        @(negedge clk_i);
        ws = 3'h4;
        ext = 1'b0;
        far = 1'b0;
        read(20'h00800, 1'b0, 5);
        read(20'h00801, 1'b0, 0);
    endtask

    task automatic t_cache;
        @(negedge clk_i);
        ws = 3'h2;
        read(20'h00A00, 1'b1, 4);
        read(20'h00A00, 1'b1, 0);
    endtask

    task automatic t_pe;
        read(20'h00100, 1'b0, 3);
        pe_run(1'b1, 3'h0, 1'b0);
        pe_run(1'b0, 3'h1, 1'b1);
        pe_run(1'b1, 3'h5, 1'b0);
        @(negedge clk_i);
        lock_valid = 1'b1;
        lock_mod = 3'h2;
        @(negedge clk_i);
        lock_valid = 1'b0;
        check("prot mask", prot, 8'h04);
        pe_run(1'b0, 3'h2, 1'b0);
        read(20'h20040, 1'b0, 3);
        pe_run(1'b1, 3'h4, 1'b1);
        pe_run(1'b0, 3'h1, 1'b0);
        // Core moves to program SRAM, old source may be erased
        @(negedge clk_i);
        sram = 1'b1;
        @(negedge clk_i);
        sram = 1'b0;
        pe_run(1'b0, 3'h1, 1'b1);
    endtask

    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            n_errors++;
            print_verdict();
        end
    end

    initial
    begin
        n_errors = 0;
        checks = 0;
        cycles = 0;
        rstn_i = 1'b0;
        ws = 3'h1;
        ext = 1'b0;
        far = 1'b0;
        sram = 1'b0;
        req_valid = 1'b0;
        req = '0;
        cmd_valid = 1'b0;
        cmd = '0;
        lock_valid = 1'b0;
        lock_mod = 3'h0;
        repeat (3) @(negedge clk_i);
        rstn_i = 1'b1;
        repeat (3) @(negedge clk_i);
        t_reset();
        t_waits();
        t_prefetch();
        t_cache();
        t_pe();
        print_verdict();
    end
endmodule // flash_access_wait_control_tb
`default_nettype wire
